// ===== core/fan_lut_entry_four_five.sv
// Fan speed table entry-four duty and entry-five limit, APB register slave
`timescale 1ns/1ns
`include "fan_lut_params.svh"

// Summary of operation
// - Low duty mode reads extended bits as zero
// - High duty mode joins extended and base bits
// - Extended bits act only at 22.5kHz PWM
// - Low duty mode uses six base bits
// - Low temp mode holds limit half bit zero
// - High temp mode joins half bit into limit
// - Limit spans 0-127.5 or 0-127 degrees
// - Above limit, output entry-five duty value
// - Compare nine or eight reading bits
// - Limit is non-negative, sign taken zero
// - Higher thresholds only via offset register
module fan_lut_entry_four_five
  import fan_lut_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  input  wire logic              ref_clk,         // 125 MHz clock
  input  wire logic              resetn,          // Async reset, active low
  input  wire logic              psel,            // APB select
  input  wire logic              penable,         // APB enable
  input  wire logic              pwrite,          // APB direction, 1 = write
  input  wire logic [ADDR_W-1:0] paddr,           // APB byte address
  input  wire logic [31:0]       pwdata,          // APB write data
  output logic      [31:0]       prdata,          // APB read data
  output logic                   pready,          // APB ready
  output logic                   pslverr,         // APB error, unmapped address
  input  wire logic [10:0]       remote_temp,     // Remote reading, 1/8 degree
  input  wire reg_byte_t         duty5_value,     // Entry-five duty from its register
  output reg_byte_t              duty4_pwm,       // Effective entry-four duty
  output half_deg_t              limit5_threshold,// Effective limit, half degrees
  output logic                   limit5_exceeded, // Reading above entry-five limit
  output reg_byte_t              pwm_duty_select  // Duty chosen by the comparison
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = ADDR_W'({idx, 2'b00});
  endfunction : reg_addr

  function automatic reg_byte_t mask_duty(input reg_byte_t v, input logic keep_ext);
    mask_duty = keep_ext ? v : {2'b00, v[`FAN_DUTY4_BASE_MSB:0]};
  endfunction : mask_duty

  function automatic reg_byte_t mask_limit(input reg_byte_t v, input res_mode_t m);
    mask_limit = (m == RES_HIGH) ? v : {1'b0, v[`FAN_LIMIT5_DEG_MSB:0]};
  endfunction : mask_limit

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  reg_byte_t ctrl;
  reg_byte_t temp_offset;
  reg_byte_t duty4;
  reg_byte_t limit5;

  wire res_mode_t duty_mode = res_mode_t'(ctrl[`FAN_CTRL_DUTY_HIRES]);
  wire res_mode_t temp_mode = res_mode_t'(ctrl[`FAN_CTRL_TEMP_HIRES]);
  wire logic      duty_hi   = (duty_mode == RES_HIGH);
  wire logic      table_wen = ctrl[`FAN_CTRL_TABLE_WREN];
  // Extended duty bits only act with the fast PWM rate selected
  wire logic      ext_on    = duty_hi & ctrl[`FAN_CTRL_PWM_22K];

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  wire logic hit_ctrl   = (paddr == reg_addr(`FAN_IDX_CTRL));
  wire logic hit_offset = (paddr == reg_addr(`FAN_IDX_TEMP_OFFSET));
  wire logic hit_duty4  = (paddr == reg_addr(`FAN_IDX_DUTY4));
  wire logic hit_limit5 = (paddr == reg_addr(`FAN_IDX_LIMIT5));
  wire logic hit_status = (paddr == reg_addr(`FAN_IDX_STATUS));
  wire logic hit_any    = hit_ctrl | hit_offset | hit_duty4 | hit_limit5 | hit_status;

  wire logic setup_phase = psel & ~penable;
  wire logic access_done = psel & penable & pready;
  wire logic wr_fire     = access_done & pwrite;

  // Table registers stay read-only until software opens them
  wire logic wr_duty4  = wr_fire & hit_duty4  & table_wen;
  wire logic wr_limit5 = wr_fire & hit_limit5 & table_wen;

  // --------------------------------------------------------------------------
  // Comparison against the entry-five limit
  // --------------------------------------------------------------------------
  half_deg_t cmp_threshold;
  logic      cmp_exceeded;

  fan_lut_limit_cmp u_limit_cmp (
    .limit_reg   (limit5),
    .temp_offset (temp_offset),
    .temp_mode   (temp_mode),
    .remote_temp (remote_temp),
    .threshold   (cmp_threshold),
    .exceeded    (cmp_exceeded)
  );

  // Low resolution keeps the six base bits only
  wire reg_byte_t duty_eff = mask_duty(duty4, ext_on);
  wire reg_byte_t next_pwm = cmp_exceeded ? duty5_value : duty_eff;

  // --------------------------------------------------------------------------
  // Read data selection
  // --------------------------------------------------------------------------
  wire reg_byte_t status_byte = reg_byte_t'({ext_on, cmp_exceeded});
  wire reg_byte_t rd_byte =
      hit_ctrl   ? ctrl :
      hit_offset ? temp_offset :
      hit_duty4  ? mask_duty(duty4, duty_hi) :
      hit_limit5 ? mask_limit(limit5, temp_mode) :
      hit_status ? status_byte : 8'h00;

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl        <= `FAN_RST_CTRL;
      temp_offset <= `FAN_RST_TEMP_OFFSET;
    end else begin
      if (wr_fire & hit_ctrl) begin
        ctrl <= pwdata[7:0];
      end
      if (wr_fire & hit_offset) begin
        temp_offset <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      duty4  <= `FAN_RST_DUTY4;
      limit5 <= `FAN_RST_LIMIT5;
    end else begin
      if (wr_duty4) begin
        duty4 <= mask_duty(pwdata[7:0], duty_hi);
      end
      if (wr_limit5) begin
        limit5 <= mask_limit(pwdata[7:0], temp_mode);
      end
    end
  end

  // --------------------------------------------------------------------------
  // APB answer
  // --------------------------------------------------------------------------
  // Read data is caught in the setup cycle, so every access ends in one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup_phase) begin
        prdata  <= {24'h00_0000, rd_byte};
        pslverr <= ~hit_any;
      end else if (access_done) begin
        pslverr <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Table outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      duty4_pwm        <= 8'h00;
      limit5_threshold <= 10'h000;
      limit5_exceeded  <= 1'b0;
      pwm_duty_select  <= 8'h00;
    end else begin
      duty4_pwm        <= duty_eff;
      limit5_threshold <= cmp_threshold;
      limit5_exceeded  <= cmp_exceeded;
      pwm_duty_select  <= next_pwm;
    end
  end

endmodule : fan_lut_entry_four_five

// ===== core/fan_lut_params.svh
// Register indices, field positions, reset values for the fan speed table slice
`ifndef FAN_LUT_PARAMS_SVH
`define FAN_LUT_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define FAN_IDX_CTRL          8'h4A
`define FAN_IDX_TEMP_OFFSET   8'h4E
`define FAN_IDX_DUTY4         8'h57
`define FAN_IDX_LIMIT5        8'h58
`define FAN_IDX_STATUS        8'h60

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define FAN_CTRL_DUTY_HIRES   0
`define FAN_CTRL_TEMP_HIRES   1
`define FAN_CTRL_PWM_22K      2
`define FAN_CTRL_TABLE_WREN   5

// ----------------------------------------------------------------------------
// Field positions inside the table and status registers
// ----------------------------------------------------------------------------
`define FAN_DUTY4_EXT_MSB     7
`define FAN_DUTY4_EXT_LSB     6
`define FAN_DUTY4_BASE_MSB    5
`define FAN_LIMIT5_HALF_BIT   7
`define FAN_LIMIT5_DEG_MSB    6
`define FAN_STATUS_EXCEEDED   0
`define FAN_STATUS_EXT_ON     1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define FAN_RST_CTRL          8'h00
`define FAN_RST_TEMP_OFFSET   8'h00
`define FAN_RST_DUTY4         8'h3F
`define FAN_RST_LIMIT5        8'h7F

`endif

// ===== core/fan_lut_pkg.sv
// Types shared by the fan speed table slice
package fan_lut_pkg;

  typedef logic [7:0] reg_byte_t;
  typedef logic [9:0] half_deg_t;

  typedef enum logic {
    RES_LOW  = 1'b0,
    RES_HIGH = 1'b1
  } res_mode_t;

endpackage : fan_lut_pkg

// ===== core/fan_lut_limit_cmp.sv
// Entry-five limit threshold build and remote temperature comparison
`timescale 1ns/1ns

module fan_lut_limit_cmp
  import fan_lut_pkg::*;
(
  input  wire reg_byte_t  limit_reg,    // Stored entry-five limit
  input  wire reg_byte_t  temp_offset,  // Table temperature offset, whole degrees
  input  wire res_mode_t  temp_mode,    // Temperature table resolution
  input  wire logic [10:0] remote_temp, // Unsigned reading, 1/8 degree per step
  output half_deg_t       threshold,    // Limit in half degrees, offset included
  output logic            exceeded      // Reading above the limit
);

  // --------------------------------------------------------------------------
  // Threshold in half-degree units
  // --------------------------------------------------------------------------
  // Sign is taken as zero always, so the top bit of each operand is 0
  wire logic half_bit = (temp_mode == RES_HIGH) ?
                        limit_reg[`FAN_LIMIT5_HALF_BIT] : 1'b0;
  wire half_deg_t base_limit = {2'b00, limit_reg[`FAN_LIMIT5_DEG_MSB:0], half_bit};
  wire half_deg_t offset_half = {1'b0, temp_offset, 1'b0};

  // Only the offset reaches beyond 127.5 degrees
  assign threshold = base_limit + offset_half;

  // --------------------------------------------------------------------------
  // Reading trimmed to nine or eight bits
  // --------------------------------------------------------------------------
  wire half_deg_t temp_half = (temp_mode == RES_HIGH) ?
                              {1'b0, remote_temp[10:2]} :
                              {1'b0, remote_temp[10:3], 1'b0};

  assign exceeded = temp_half > threshold;

endmodule : fan_lut_limit_cmp

// ===== sim/fan_lut_checker.sv
// Port assertions for the fan speed table slice
`timescale 1ns/1ns
`include "fan_lut_params.svh"
module fan_lut_checker
  import fan_lut_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  input wire logic              ref_clk,          // Clock
  input wire logic              resetn,           // Reset, active low
  input wire logic              psel,             // APB select
  input wire logic              penable,          // APB enable
  input wire logic [ADDR_W-1:0] paddr,            // APB address
  input wire logic [31:0]       prdata,           // APB read data
  input wire logic              pready,           // APB ready
  input wire logic              pslverr,          // APB error
  input wire logic [10:0]       remote_temp,      // Reading
  input wire reg_byte_t         duty5_value,      // Entry-five duty
  input wire reg_byte_t         duty4_pwm,        // Entry-four duty
  input wire half_deg_t         limit5_threshold, // Limit
  input wire logic              limit5_exceeded,  // Above limit
  input wire reg_byte_t         pwm_duty_select   // Chosen duty
);
  wire logic mapped = paddr == 4*`FAN_IDX_CTRL || paddr == 4*`FAN_IDX_TEMP_OFFSET ||
    paddr == 4*`FAN_IDX_DUTY4 || paddr == 4*`FAN_IDX_LIMIT5 || paddr == 4*`FAN_IDX_STATUS;
  wire logic setup = psel && !penable;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_ready_on_access: assert property (setup |=> pready)
    else $error("pready low in access phase");
  a_err_unmapped: assert property (setup && !mapped |=> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped_none: assert property (setup && mapped |=> !pslverr)
    else $error("error on mapped address");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  a_rdata_byte: assert property (psel && penable && pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_ready_stays: assert property (pready |=> pready)
    else $error("pready dropped");
  a_select_duty: assert property (pwm_duty_select ==
    (limit5_exceeded ? $past(duty5_value) : duty4_pwm)) else $error("wrong duty chosen");
  // Low resolution drops reading bit 2, so compare only where both readings agree
  a_exceed_cmp: assert property (pready && (!$past(remote_temp[2]) || limit5_threshold[0])
    |-> limit5_exceeded == ({1'b0, $past(remote_temp[10:2])} > limit5_threshold))
    else $error("limit comparison wrong");
endmodule : fan_lut_checker

bind fan_lut_entry_four_five fan_lut_checker #(.ADDR_W(ADDR_W)) u_chk (.ref_clk(ref_clk),
  .resetn(resetn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .remote_temp(remote_temp), .duty5_value(duty5_value),
  .duty4_pwm(duty4_pwm), .limit5_threshold(limit5_threshold),
  .limit5_exceeded(limit5_exceeded), .pwm_duty_select(pwm_duty_select));

// ===== sim/testbench.sv
// Self-checking testbench for the fan speed table slice
`timescale 1ns/1ns
`include "fan_lut_params.svh"
module testbench
  import fan_lut_pkg::*;
;
  logic        ref_clk, resetn, psel, penable, pwrite, pready, pslverr, err, exc;
  logic        limit5_exceeded;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [10:0] remote_temp, rt;
  reg_byte_t   duty5_value, duty4_pwm, pwm_duty_select, ctrl, d4, l5, off;
  half_deg_t   limit5_threshold, thr;
  int          fail_count = 0;
  int          n_compared = 0;
  localparam logic [11:0] A_CTRL = 12'(4*`FAN_IDX_CTRL);
  localparam logic [11:0] A_OFF  = 12'(4*`FAN_IDX_TEMP_OFFSET);
  localparam logic [11:0] A_DUTY = 12'(4*`FAN_IDX_DUTY4);
  localparam logic [11:0] A_LIM  = 12'(4*`FAN_IDX_LIMIT5);
  localparam logic [11:0] A_STAT = 12'(4*`FAN_IDX_STATUS);

  fan_lut_entry_four_five #(.ADDR_W(12)) i_dut (.ref_clk(ref_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .remote_temp(remote_temp),
    .duty5_value(duty5_value), .duty4_pwm(duty4_pwm), .limit5_threshold(limit5_threshold),
    .limit5_exceeded(limit5_exceeded), .pwm_duty_select(pwm_duty_select));

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic half_deg_t thr_f(reg_byte_t c, reg_byte_t l, reg_byte_t o);
    return (c[1] ? {2'b00, l[6:0], l[7]} : {2'b00, l[6:0], 1'b0}) + {1'b0, o, 1'b0};
  endfunction : thr_f
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Leaves the bus selected so the next transfer may follow back to back
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
  endtask : apb
  task automatic idle(input int n);
    psel <= 1'b0; penable <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask : idle
  task automatic close_out;
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
  initial begin
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    remote_temp = '0; duty5_value = '0; seed = 32'h5835;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    apb(0, A_DUTY, 0); chk(rd, 32'h3F);
    apb(0, A_LIM, 0); chk(rd, 32'h7F);
    apb(1, A_DUTY, 32'h12); apb(0, A_DUTY, 0); chk(rd, 32'h3F);
    apb(1, 12'hFFC, 32'hFF); apb(0, 12'hFFC, 0); chk({rd[31:1], err}, 32'h1);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      ctrl = {2'b00, 1'b1, 2'b00, i[2:0]};
      d4 = seed[7:0]; l5 = seed[15:8]; off = i[3] ? 8'h00 : seed[23:16];
      if (i == 38) begin d4 = 8'hFF; l5 = 8'hFF; off = 8'hFF; end
      thr = thr_f(ctrl, l5, off);
      // Equal and one step above the limit sit on the strict-compare boundary
      rt = (i[4] ^ i[3]) ? {thr[8:0], 2'b00} + {i[4], 2'b00} : seed[31:21];
      exc = {1'b0, (ctrl[1] ? rt[10:2] : {rt[10:3], 1'b0})} > thr;
      remote_temp <= rt; duty5_value <= seed[29:22];
      apb(1, A_CTRL, ctrl); apb(1, A_OFF, off); apb(1, A_DUTY, d4); apb(1, A_LIM, l5);
      apb(0, A_DUTY, 0); chk(rd, ctrl[0] ? d4 : d4 & 8'h3F);
      apb(0, A_LIM, 0); chk(rd, ctrl[1] ? l5 : l5 & 8'h7F);
      idle(2);
      chk(duty4_pwm, (ctrl[0] & ctrl[2]) ? d4 : d4 & 8'h3F);
      chk(limit5_threshold, thr);
      chk(limit5_exceeded, exc);
      chk(pwm_duty_select, exc ? seed[29:22] : ((ctrl[0] & ctrl[2]) ? d4 : d4 & 8'h3F));
      apb(0, A_STAT, 0); chk(rd[1:0], {ctrl[0] & ctrl[2], exc});
    end
    apb(1, A_CTRL, 0); apb(1, A_LIM, 0); apb(0, A_LIM, 0); chk(rd, l5 & 8'h7F);
    idle(2);
    close_out();
  end
endmodule : testbench
